//--- src/pxirq_flags.sv
`default_nettype none
module pxirq_flags
   import pxirq_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // port pins, asynchronous to i_clk
   input wire logic i_port_zero_pin_a,
   input wire logic i_port_zero_pin_b,
   input wire logic i_port_zero_pin_c,
   // edge choice per input, 1 rising, 0 falling
   input wire logic [2:0] i_edge_rising,
   // register port, direct addressing only
   input wire logic i_reg_wr,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // cpu level requests
   output logic o_cpu_level_four,
   output logic o_cpu_level_five,
   output logic o_cpu_level_six
);
   logic [2:0] pins;
   logic [2:0] edge_hit;
   logic [2:0] pend;
   logic [2:0] en;
   logic [2:0] next_pend;
   logic [2:0] next_en;
   logic [2:0] wr_pend;
   logic [2:0] clr;
   logic [7:0] next_rdata;
   logic [2:0] next_req;
   logic [2:0] req;

   // bit 0 is ext_irq_zero, bit 2 is ext_irq_two
   assign pins = {i_port_zero_pin_c, i_port_zero_pin_b, i_port_zero_pin_a};

   // the register port has no address: it stands for the single direct
   // register location, so indirect forms never reach it
   assign wr_pend = i_reg_wdata[PXIRQ_PEND_LSB +: PXIRQ_N_IN];

   // pending field must sit above the enable field inside the register
   if (PXIRQ_PEND_LSB + PXIRQ_N_IN > PXIRQ_REG_W ||
         PXIRQ_EN_LSB + PXIRQ_N_IN > PXIRQ_PEND_LSB) begin : g_bad_layout
      $error("register field layout does not fit the register");
   end

   genvar g;
   generate
      for (g = 0; g < PXIRQ_N_IN; g++) begin : g_in
         pxirq_edge u_edge (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_pin(pins[g]),
            .i_rising(i_edge_rising[g]),
            .o_edge(edge_hit[g])
         );
      end
   endgenerate

   always_comb begin
      // only a written zero clears; a written one is ignored
      clr = i_reg_wr ? ~wr_pend : 3'h0;
      // an edge in the clearing cycle wins, so no event is lost
      next_pend = (pend & ~clr) | edge_hit;
      next_en = en;
      if (i_reg_wr) begin
         next_en = i_reg_wdata[PXIRQ_EN_LSB +: PXIRQ_N_IN];
      end
      // request needs both flag and enable
      next_req = pend & en;
      // unused positions read zero
      next_rdata = 8'h00;
      next_rdata[PXIRQ_PEND_LSB +: PXIRQ_N_IN] = pend;
      next_rdata[PXIRQ_EN_LSB +: PXIRQ_N_IN] = en;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pend <= PXIRQ_PEND_RST;
         en <= PXIRQ_EN_RST;
         req <= 3'h0;
         o_reg_rdata <= PXIRQ_RDATA_RST;
      end else begin
         pend <= next_pend;
         en <= next_en;
         req <= next_req;
         o_reg_rdata <= next_rdata;
      end
   end

   // outputs straight from the request flops; one cycle after the flag
   assign o_cpu_level_four = req[0];
   assign o_cpu_level_five = req[1];
   assign o_cpu_level_six = req[2];

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rstn);

   property p_pend_two_set;
      edge_hit[2] |=> pend[2] ##1 o_reg_rdata[6];
   endproperty
   a_pend_two_set: assert property (p_pend_two_set)
      else $error("edge on input two did not show as pending");

   property p_pend_one_set;
      edge_hit[1] |=> pend[1] ##1 o_reg_rdata[5];
   endproperty
   a_pend_one_set: assert property (p_pend_one_set)
      else $error("edge on input one did not show as pending");

   property p_pend_zero_hold;
      pend[0] && !(i_reg_wr && !i_reg_wdata[4]) |=> pend[0];
   endproperty
   a_pend_zero_hold: assert property (p_pend_zero_hold)
      else $error("pending zero dropped without a clearing write");

   property p_clear_on_zero;
      i_reg_wr && !i_reg_wdata[6] && !edge_hit[2] |=> !pend[2];
   endproperty
   a_clear_on_zero: assert property (p_clear_on_zero)
      else $error("written zero did not clear pending two");

   property p_one_no_effect;
      i_reg_wr && i_reg_wdata[5] && !pend[1] && !edge_hit[1] |=> !pend[1];
   endproperty
   a_one_no_effect: assert property (p_one_no_effect)
      else $error("written one set pending one");

   property p_level_six;
      ##1 o_cpu_level_six == ($past(pend[2]) && $past(en[2]));
   endproperty
   a_level_six: assert property (p_level_six)
      else $error("level six request does not follow flag and enable");

   property p_level_five_blocked;
      !en[1] ##1 !en[1] |-> !o_cpu_level_five;
   endproperty
   a_level_five_blocked: assert property (p_level_five_blocked)
      else $error("level five raised while disabled");

   property p_level_four_raise;
      pend[0] && en[0] |=> o_cpu_level_four;
   endproperty
   a_level_four_raise: assert property (p_level_four_raise)
      else $error("level four not raised with flag and enable set");

   property p_unused_zero;
      o_reg_rdata[PXIRQ_UNUSED_HI] == 1'b0 &&
         o_reg_rdata[PXIRQ_UNUSED_MID] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("unused register bit reads one");

   property p_enable_write;
      i_reg_wr |=> en == $past(i_reg_wdata[2:0]) ##1
         o_reg_rdata[2:0] == $past(en);
   endproperty
   a_enable_write: assert property (p_enable_write)
      else $error("enable bits not taken from write data");

   property p_pend_zero_set;
      edge_hit[0] |=> pend[0] ##1 o_reg_rdata[PXIRQ_PEND_LSB];
   endproperty
   a_pend_zero_set: assert property (p_pend_zero_set)
      else $error("edge on input zero did not show as pending");

   property p_clear_one;
      i_reg_wr && !i_reg_wdata[PXIRQ_PEND_LSB + 1] && !edge_hit[1]
         |=> !pend[1];
   endproperty
   a_clear_one: assert property (p_clear_one)
      else $error("written zero did not clear pending one");

   property p_clear_zero;
      i_reg_wr && !i_reg_wdata[PXIRQ_PEND_LSB] && !edge_hit[0]
         |=> !pend[0];
   endproperty
   a_clear_zero: assert property (p_clear_zero)
      else $error("written zero did not clear pending zero");

   property p_one_no_effect_two;
      i_reg_wr && i_reg_wdata[PXIRQ_PEND_LSB + 2] && !pend[2] &&
         !edge_hit[2] |=> !pend[2];
   endproperty
   a_one_no_effect_two: assert property (p_one_no_effect_two)
      else $error("written one set pending two");

   property p_level_six_blocked;
      !en[2] |=> !o_cpu_level_six;
   endproperty
   a_level_six_blocked: assert property (p_level_six_blocked)
      else $error("level six raised while disabled");

   property p_level_four_blocked;
      !en[0] |=> !o_cpu_level_four;
   endproperty
   a_level_four_blocked: assert property (p_level_four_blocked)
      else $error("level four raised while disabled");

   property p_set_by_edge_only;
      1'b1 |=> (pend & ~($past(pend) | $past(edge_hit))) == 3'h0;
   endproperty
   a_set_by_edge_only: assert property (p_set_by_edge_only)
      else $error("pending flag set without an edge");

   property p_rdata_pending;
      ##1 o_reg_rdata[PXIRQ_PEND_LSB +: PXIRQ_N_IN] == $past(pend);
   endproperty
   a_rdata_pending: assert property (p_rdata_pending)
      else $error("read data does not show the pending flags");

   property p_level_five_raise;
      pend[1] && en[1] |=> o_cpu_level_five;
   endproperty
   a_level_five_raise: assert property (p_level_five_raise)
      else $error("level five not raised with flag and enable set");
endmodule : pxirq_flags
`default_nettype wire

//--- src/pxirq_pkg.sv
`default_nettype none
package pxirq_pkg;
   // register width and number of external inputs
   localparam int PXIRQ_REG_W = 8;
   localparam int PXIRQ_N_IN = 3;
   // field positions in the pending/enable register
   localparam int PXIRQ_PEND_LSB = 4;
   localparam int PXIRQ_EN_LSB = 0;
   localparam int PXIRQ_UNUSED_HI = 7;
   localparam int PXIRQ_UNUSED_MID = 3;
   // reset values
   localparam logic [2:0] PXIRQ_PEND_RST = 3'h0;
   localparam logic [2:0] PXIRQ_EN_RST = 3'h0;
   localparam logic [7:0] PXIRQ_RDATA_RST = 8'h00;
   // synchroniser depth ahead of the edge detector
   localparam int PXIRQ_SYNC_STAGES = 2;
endpackage : pxirq_pkg
`default_nettype wire

//--- src/pxirq_edge.sv
`default_nettype none
module pxirq_edge
   import pxirq_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // pin and edge choice
   input wire logic i_pin,
   input wire logic i_rising,
   // detected edge
   output logic o_edge
);
   logic sync_a;
   logic sync_b;
   logic prev;
   logic next_edge;
   // fills with ones after reset; marks sync and prev as real samples
   logic [PXIRQ_SYNC_STAGES:0] fill;

   // first stage feeds only the second; metastability stays contained
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
         fill <= '0;
      end else begin
         sync_a <= i_pin;
         sync_b <= sync_a;
         prev <= sync_b;
         fill <= {fill[PXIRQ_SYNC_STAGES-1:0], 1'b1};
      end
   end

   // no edge until filled: a pin resting opposite the reset value would
   // fake one; an edge in the first cycles after reset is lost instead
   always_comb begin
      if (i_rising) begin
         next_edge = fill[PXIRQ_SYNC_STAGES] & sync_b & ~prev;
      end else begin
         next_edge = fill[PXIRQ_SYNC_STAGES] & ~sync_b & prev;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_edge <= 1'b0;
      end else begin
         o_edge <= next_edge;
      end
   end
endmodule : pxirq_edge
`default_nettype wire

//--- testbench/test_port0_ext_irq_flags.sv
`default_nettype none
module test_port0_ext_irq_flags;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [2:0] rise;
      logic [2:0] base;
      logic [2:0] pins;
      logic [2:0] en;
      logic [7:0] rd;
      logic [2:0] lv;
   } pxirq_row_t;
   logic i_clk;
   logic i_rstn;
   logic [2:0] pin;
   logic [2:0] i_edge_rising;
   logic i_reg_wr;
   logic [7:0] i_reg_wdata;
   logic [7:0] o_reg_rdata;
   wire [2:0] lv;
   int error_cnt = 0;
   int comparisons = 0;
   int cycles = 0;
   pxirq_row_t rows [5];
   pxirq_flags dut (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_port_zero_pin_a(pin[0]),
      .i_port_zero_pin_b(pin[1]),
      .i_port_zero_pin_c(pin[2]),
      .i_edge_rising(i_edge_rising),
      .i_reg_wr(i_reg_wr),
      .i_reg_wdata(i_reg_wdata),
      .o_reg_rdata(o_reg_rdata),
      .o_cpu_level_four(lv[0]),
      .o_cpu_level_five(lv[1]),
      .o_cpu_level_six(lv[2])
   );
   task automatic test_done();
      $display("checks %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : test_done
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   task automatic tick();
      @(posedge i_clk);
      #2;
   endtask : tick
   // plain strobe and data, the direct register form only
   // rdata shows the write one edge after it lands
   task automatic wr(logic [7:0] d);
      i_reg_wr = 1'b1;
      i_reg_wdata = d;
      tick();
      i_reg_wr = 1'b0;
      tick();
   endtask : wr
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles = cycles + 1;
      if (cycles == 1000) begin
         error_cnt++;
         test_done();
      end
   end
   initial begin
      // row: rise, base, pins, en, rdata, {six,five,four}
      rows[0] = '{3'h7, 3'h0, 3'h1, 3'h7, 8'h17, 3'h1};
      rows[1] = '{3'h7, 3'h0, 3'h2, 3'h2, 8'h22, 3'h2};
      rows[2] = '{3'h7, 3'h0, 3'h4, 3'h3, 8'h43, 3'h0};
      rows[3] = '{3'h0, 3'h7, 3'h3, 3'h4, 8'h44, 3'h4};
      rows[4] = '{3'h7, 3'h0, 3'h7, 3'h0, 8'h70, 3'h0};
      i_rstn = 1'b0;
      pin = 3'h0;
      i_edge_rising = 3'h7;
      i_reg_wr = 1'b0;
      i_reg_wdata = 8'h00;
      repeat (3) @(posedge i_clk);
      #2;
      i_rstn = 1'b1;
      chk("rdata after reset", o_reg_rdata, 8'h00);
      chk("levels after reset", {5'h00, lv}, 8'h00);
      foreach (rows[i]) begin
         i_edge_rising = rows[i].rise;
         pin = rows[i].base;
         // let baseline edges settle before clearing
         repeat (6) tick();
         wr({5'h00, rows[i].en});
         pin = rows[i].pins;
         repeat (7) tick();
         chk("rdata", o_reg_rdata, rows[i].rd);
         chk("levels", {5'h00, lv}, {5'h00, rows[i].lv});
         $display("row %0d done", i);
      end
      wr(8'hFF);
      chk("ones kept", o_reg_rdata, 8'h77);
      chk("levels on", {5'h00, lv}, 8'h07);
      wr(8'hD7);
      chk("clear one", o_reg_rdata, 8'h57);
      chk("level five off", {5'h00, lv}, 8'h05);
      wr(8'hF7);
      chk("one no set", o_reg_rdata, 8'h57);
      $display("write tests done");
      i_rstn = 1'b0;
      #1;
      chk("rdata in reset", o_reg_rdata, 8'h00);
      chk("levels in reset", {5'h00, lv}, 8'h00);
      tick();
      i_rstn = 1'b1;
      // pins rest high: no false edge may follow the release
      repeat (6) tick();
      chk("rdata after release", o_reg_rdata, 8'h00);
      chk("levels after release", {5'h00, lv}, 8'h00);
      $display("reset test done");
      test_done();
   end
endmodule : test_port0_ext_irq_flags
`default_nettype wire
